// file: hw/acm_entry_matcher.sv
module acm_entry_matcher (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic  [1:0] htrans,
	input  wire logic        hwrite,
	input  wire logic  [2:0] hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Parsed header from the frame parser
	input  wire logic        frame_valid,
	input  wire logic        frame_is_ipv4,
	input  wire logic  [7:0] frame_protocol,
	input  wire logic  [7:0] frame_ttl,
	input  wire logic        frame_more_frag,
	input  wire logic [12:0] frame_frag_offset,
	input  wire logic  [3:0] frame_header_len,
	input  wire logic [31:0] frame_src_addr,
	input  wire logic [31:0] frame_dst_addr,
	// Layer 4 sub-criteria results
	input  wire logic        icmp_criteria_ok,
	input  wire logic        udp_criteria_ok,
	input  wire logic        tcp_criteria_ok,
	// Match result
	output logic             entry_hit_valid,
	output logic             entry_hit
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [13:0] ctrl_reg;         // Entry control fields
	logic  [7:0] proto_val_reg;    // Specific protocol value
	logic [31:0] src_addr_reg;     // Configured source address
	logic [31:0] src_mask_reg;     // Configured source mask
	logic [31:0] dst_addr_reg;     // Configured destination address
	logic [31:0] dst_mask_reg;     // Configured destination mask
	logic [31:0] hit_count_reg;    // Frames that hit
	logic        seen_reg;         // Sticky frame seen
	logic        wr_pend_reg;      // Write data phase pending
	logic  [7:0] wr_addr_reg;      // Offset of pending write
	logic        hreadyout_reg;    // Ready answer
	logic        hresp_reg;        // Always OKAY
	logic [31:0] hrdata_reg;       // Read data for data phase
	logic        hit_valid_reg;    // Result strobe
	logic        hit_reg;          // Result level

	// ----------------------------------------
	// Decoded control fields
	// ----------------------------------------
	logic                   entry_ipv4;   // Entry selects IPv4
	acm_pkg::acm_proto_e    proto_mode;   // Protocol filter
	acm_pkg::acm_tri_e      ttl_mode;     // TTL filter
	acm_pkg::acm_tri_e      frag_mode;    // Fragment filter
	acm_pkg::acm_tri_e      opt_mode;     // Option filter
	logic             [1:0] src_mode;     // Source address filter
	logic             [1:0] dst_mode;     // Destination address filter

	assign entry_ipv4 = ctrl_reg[acm_pkg::CTL_IPV4];
	assign proto_mode = acm_pkg::acm_proto_e'(ctrl_reg[acm_pkg::CTL_PROTO +: 3]);
	assign ttl_mode   = acm_pkg::acm_tri_e'(ctrl_reg[acm_pkg::CTL_TTL +: 2]);
	assign frag_mode  = acm_pkg::acm_tri_e'(ctrl_reg[acm_pkg::CTL_FRAG +: 2]);
	assign opt_mode   = acm_pkg::acm_tri_e'(ctrl_reg[acm_pkg::CTL_OPT +: 2]);
	assign src_mode   = ctrl_reg[acm_pkg::CTL_SRC +: 2];
	assign dst_mode   = ctrl_reg[acm_pkg::CTL_DST +: 2];

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        bus_take;    // Address phase accepted
	logic        wr_now;      // Write data present
	logic [31:0] rd_next;     // Read mux
	logic        hcnt_clr;    // Counter cleared by software
	logic        seen_clr;    // Sticky bit cleared by software

	// Single slave, so hready is our own ready; NONSEQ and SEQ both start a transfer
	assign bus_take = hsel && hready && htrans[1];
	assign wr_now   = wr_pend_reg;
	assign hcnt_clr = wr_now && (wr_addr_reg == acm_pkg::OFS_HCNT);
	assign seen_clr = wr_now && (wr_addr_reg == acm_pkg::OFS_STAT) && hwdata[acm_pkg::ST_SEEN];

	// Capture the address phase; only whole words are expected, hsize is not checked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (bus_take) begin
			wr_pend_reg <= hwrite;
			wr_addr_reg <= haddr[7:0];
		end else begin
			wr_pend_reg <= 1'b0;
		end
	end

	// Zero wait states and no errors; held in flops so outputs come from registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end else begin
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rd_next = 32'h0000_0000;
		case (haddr[7:0])
			acm_pkg::OFS_CTRL:  rd_next[acm_pkg::CTL_W-1:0] = ctrl_reg;
			acm_pkg::OFS_PROTO: rd_next[7:0] = proto_val_reg;
			acm_pkg::OFS_SRC:   rd_next = src_addr_reg;
			acm_pkg::OFS_SMASK: rd_next = src_mask_reg;
			acm_pkg::OFS_DST:   rd_next = dst_addr_reg;
			acm_pkg::OFS_DMASK: rd_next = dst_mask_reg;
			acm_pkg::OFS_STAT:  rd_next[acm_pkg::ST_SEEN:acm_pkg::ST_LAST] = {seen_reg, hit_reg};
			acm_pkg::OFS_HCNT:  rd_next = hit_count_reg;
			default:            rd_next = 32'h0000_0000;
		endcase
	end

	// Read data is latched at the address phase and stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (bus_take && !hwrite) begin
			hrdata_reg <= rd_next;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Written in the data phase; a new configuration applies from the next frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg      <= acm_pkg::CTRL_RST;
			proto_val_reg <= acm_pkg::PROTO_RST;
			src_addr_reg  <= acm_pkg::ADDR_RST;
			src_mask_reg  <= acm_pkg::ADDR_RST;
			dst_addr_reg  <= acm_pkg::ADDR_RST;
			dst_mask_reg  <= acm_pkg::ADDR_RST;
		end else if (wr_now) begin
			case (wr_addr_reg)
				acm_pkg::OFS_CTRL:  ctrl_reg <= hwdata[acm_pkg::CTL_W-1:0];
				acm_pkg::OFS_PROTO: proto_val_reg <= hwdata[7:0];
				acm_pkg::OFS_SRC:   src_addr_reg <= hwdata;
				acm_pkg::OFS_SMASK: src_mask_reg <= hwdata;
				acm_pkg::OFS_DST:   dst_addr_reg <= hwdata;
				acm_pkg::OFS_DMASK: dst_mask_reg <= hwdata;
				default: begin
					// Status and counter writes act below; unmapped: ignored
				end
			endcase
		end
	end

	// ----------------------------------------
	// Header checks
	// ----------------------------------------
	logic frame_ok;     // Frame type check
	logic proto_ok;     // Protocol check
	logic ttl_ok;       // TTL check
	logic frag_ok;      // Fragment check
	logic opt_ok;       // Option check
	logic src_ok;       // Source address check
	logic dst_ok;       // Destination address check
	logic fragmented;   // Frame is a fragment
	logic has_options;  // Header longer than five words
	logic hit_next;     // All checks pass

	// An entry not typed IPv4 never hits
	assign frame_ok    = entry_ipv4 && frame_is_ipv4;
	assign fragmented  = frame_more_frag || (frame_frag_offset != 13'h0000);
	assign has_options = frame_header_len > acm_pkg::MIN_IHL;

	// Protocol filter; layer 4 results come from the sub-criteria logic
	always_comb begin
		case (proto_mode)
			acm_pkg::PRM_ANY:  proto_ok = 1'b1;
			acm_pkg::PRM_SPEC: proto_ok = frame_protocol == proto_val_reg;
			acm_pkg::PRM_ICMP: proto_ok = (frame_protocol == acm_pkg::PROT_ICMP) && icmp_criteria_ok;
			acm_pkg::PRM_UDP:  proto_ok = (frame_protocol == acm_pkg::PROT_UDP) && udp_criteria_ok;
			acm_pkg::PRM_TCP:  proto_ok = (frame_protocol == acm_pkg::PROT_TCP) && tcp_criteria_ok;
			default:           proto_ok = 1'b0;
		endcase
	end

	// TTL filter
	always_comb begin
		case (ttl_mode)
			acm_pkg::TRI_ANY: ttl_ok = 1'b1;
			acm_pkg::TRI_NO:  ttl_ok = frame_ttl == 8'h00;
			acm_pkg::TRI_YES: ttl_ok = frame_ttl != 8'h00;
			default:          ttl_ok = 1'b0;
		endcase
	end

	// Fragment filter
	always_comb begin
		case (frag_mode)
			acm_pkg::TRI_ANY: frag_ok = 1'b1;
			acm_pkg::TRI_NO:  frag_ok = !fragmented;
			acm_pkg::TRI_YES: frag_ok = fragmented;
			default:          frag_ok = 1'b0;
		endcase
	end

	// Option filter
	always_comb begin
		case (opt_mode)
			acm_pkg::TRI_ANY: opt_ok = 1'b1;
			acm_pkg::TRI_NO:  opt_ok = !has_options;
			acm_pkg::TRI_YES: opt_ok = has_options;
			default:          opt_ok = 1'b0;
		endcase
	end

	// Source and destination address filters
	acm_addr_filter #(.ADDR_W(32)) u_src (
		.mode       (src_mode),
		.cfg_addr   (src_addr_reg),
		.cfg_mask   (src_mask_reg),
		.frame_addr (frame_src_addr),
		.pass       (src_ok)
	);

	acm_addr_filter #(.ADDR_W(32)) u_dst (
		.mode       (dst_mode),
		.cfg_addr   (dst_addr_reg),
		.cfg_mask   (dst_mask_reg),
		.frame_addr (frame_dst_addr),
		.pass       (dst_ok)
	);

	assign hit_next = frame_ok && proto_ok && ttl_ok && frag_ok && opt_ok && src_ok && dst_ok;

	// ----------------------------------------
	// Result and statistics
	// ----------------------------------------
	// One cycle of latency; the result level holds until the next frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hit_valid_reg <= 1'b0;
			hit_reg       <= 1'b0;
		end else begin
			hit_valid_reg <= frame_valid;
			if (frame_valid) begin
				hit_reg <= hit_next;
			end
		end
	end

	// A hit in the same cycle as a clear is counted, not lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hit_count_reg <= 32'h0000_0000;
		end else if (frame_valid && hit_next) begin
			hit_count_reg <= hcnt_clr ? 32'h0000_0001 : hit_count_reg + 32'h0000_0001;
		end else if (hcnt_clr) begin
			hit_count_reg <= 32'h0000_0000;
		end
	end

	// Sticky frame seen; the set wins over a write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen_reg <= 1'b0;
		end else if (frame_valid) begin
			seen_reg <= 1'b1;
		end else if (seen_clr) begin
			seen_reg <= 1'b0;
		end
	end

	assign hreadyout       = hreadyout_reg;
	assign hresp           = hresp_reg;
	assign hrdata          = hrdata_reg;
	assign entry_hit_valid = hit_valid_reg;
	assign entry_hit       = hit_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_non_ipv4;
		frame_valid && !(entry_ipv4 && frame_is_ipv4);
	endsequence
	sequence s_ttl_bad;
		frame_valid && ((ttl_mode == acm_pkg::TRI_NO && frame_ttl != 8'h00) ||
			(ttl_mode == acm_pkg::TRI_YES && frame_ttl == 8'h00));
	endsequence
	sequence s_frag_bad;
		frame_valid && ((frag_mode == acm_pkg::TRI_NO && fragmented) ||
			(frag_mode == acm_pkg::TRI_YES && !fragmented));
	endsequence
	sequence s_opt_bad;
		frame_valid && ((opt_mode == acm_pkg::TRI_NO && has_options) ||
			(opt_mode == acm_pkg::TRI_YES && !has_options));
	endsequence
	sequence s_proto_bad;
		frame_valid && ((proto_mode == acm_pkg::PRM_SPEC && frame_protocol != proto_val_reg) ||
			(proto_mode == acm_pkg::PRM_TCP && frame_protocol != 8'h06) ||
			(proto_mode == acm_pkg::PRM_UDP && frame_protocol != 8'h11) ||
			(proto_mode == acm_pkg::PRM_ICMP && frame_protocol != 8'h01));
	endsequence
	sequence s_src_bad;
		frame_valid && ((src_mode == acm_pkg::ADR_HOST && frame_src_addr != src_addr_reg) ||
			(src_mode == acm_pkg::ADR_NET && ((frame_src_addr ^ src_addr_reg) & src_mask_reg) != 0));
	endsequence
	sequence s_all_pass;
		frame_valid && entry_ipv4 && frame_is_ipv4 && proto_mode == acm_pkg::PRM_ANY &&
			ttl_mode == acm_pkg::TRI_ANY && frag_mode == acm_pkg::TRI_ANY &&
			opt_mode == acm_pkg::TRI_ANY && src_mode == acm_pkg::ADR_ANY &&
			dst_mode == acm_pkg::ADR_ANY;
	endsequence

	a_ipv4_only_hit: assert property (s_non_ipv4 |=> entry_hit_valid && !entry_hit)
		else $error("hit on a frame not typed IPv4");
	a_ttl_mode_hit: assert property (s_ttl_bad |=> !entry_hit)
		else $error("hit despite TTL setting");
	a_frag_mode_hit: assert property (s_frag_bad |=> !entry_hit)
		else $error("hit despite fragment setting");
	a_opt_mode_hit: assert property (s_opt_bad |=> !entry_hit)
		else $error("hit despite option setting");
	a_proto_mode_hit: assert property (s_proto_bad |=> !entry_hit)
		else $error("hit despite protocol setting");
	a_src_addr_hit: assert property (s_src_bad |=> !entry_hit)
		else $error("hit despite source address setting");
	a_all_pass_hit: assert property (s_all_pass |=> entry_hit_valid && entry_hit)
		else $error("no hit although every check passes");
	a_hit_holds_idle: assert property (!frame_valid |=> $stable(entry_hit))
		else $error("hit changed without a frame");
	a_bus_okay_ready: assert property (hreadyout && !hresp)
		else $error("slave not ready or not OKAY");

endmodule

// file: hw/acm_pkg.sv
package acm_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0]  OFS_CTRL   = 8'h00; // Entry control word
	localparam logic [7:0]  OFS_PROTO  = 8'h04; // Specific protocol value
	localparam logic [7:0]  OFS_SRC    = 8'h08; // Source address
	localparam logic [7:0]  OFS_SMASK  = 8'h0c; // Source prefix mask
	localparam logic [7:0]  OFS_DST    = 8'h10; // Destination address
	localparam logic [7:0]  OFS_DMASK  = 8'h14; // Destination prefix mask
	localparam logic [7:0]  OFS_STAT   = 8'h18; // Status, read side
	localparam logic [7:0]  OFS_HCNT   = 8'h1c; // Hit counter

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int          CTL_IPV4   = 0;     // Frame type is IPv4
	localparam int          CTL_PROTO  = 1;     // Three bits
	localparam int          CTL_TTL    = 4;     // Two bits
	localparam int          CTL_FRAG   = 6;     // Two bits
	localparam int          CTL_OPT    = 8;     // Two bits
	localparam int          CTL_SRC    = 10;    // Two bits
	localparam int          CTL_DST    = 12;    // Two bits
	localparam int          CTL_W      = 14;    // Used control width
	localparam int          ST_LAST    = 0;     // Last frame result
	localparam int          ST_SEEN    = 1;     // Sticky frame seen

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [13:0] CTRL_RST   = 14'h0000;
	localparam logic [7:0]  PROTO_RST  = 8'h00;
	localparam logic [31:0] ADDR_RST   = 32'h0000_0000;

	// ----------------------------------------
	// Header constants
	// ----------------------------------------
	localparam logic [7:0]  PROT_ICMP  = 8'h01;
	localparam logic [7:0]  PROT_TCP   = 8'h06;
	localparam logic [7:0]  PROT_UDP   = 8'h11;
	localparam logic [3:0]  MIN_IHL    = 4'h5;  // Header words without options

	// ----------------------------------------
	// Mode encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		PRM_ANY  = 3'h0,
		PRM_SPEC = 3'h1,
		PRM_ICMP = 3'h2,
		PRM_UDP  = 3'h3,
		PRM_TCP  = 3'h4
	} acm_proto_e;

	// Shared by TTL, fragment and option checks
	typedef enum logic [1:0] {
		TRI_ANY = 2'h0,
		TRI_NO  = 2'h1,
		TRI_YES = 2'h2
	} acm_tri_e;

	typedef enum logic [1:0] {
		ADR_ANY  = 2'h0,
		ADR_HOST = 2'h1,
		ADR_NET  = 2'h2
	} acm_addr_e;

endpackage

// file: hw/acm_addr_filter.sv
// ----------------------------------------
// Address filter for one direction
// ----------------------------------------
module acm_addr_filter #(
	parameter int ADDR_W = 32
) (
	// Configuration
	input  wire logic              [1:0] mode,
	input  wire logic        [ADDR_W-1:0] cfg_addr,
	input  wire logic        [ADDR_W-1:0] cfg_mask,
	// Frame field
	input  wire logic        [ADDR_W-1:0] frame_addr,
	// Result
	output logic                          pass
);

	// ----------------------------------------
	// Compare by mode
	// ----------------------------------------
	// Unused code 3 never passes, so a bad write cannot open the entry
	always_comb begin
		case (mode)
			acm_pkg::ADR_ANY: begin
				pass = 1'b1;
			end
			acm_pkg::ADR_HOST: begin
				pass = (frame_addr == cfg_addr);
			end
			acm_pkg::ADR_NET: begin
				// Only mask-selected bits take part
				pass = ((frame_addr ^ cfg_addr) & cfg_mask) == '0;
			end
			default: begin
				pass = 1'b0;
			end
		endcase
	end

endmodule

// file: test/acm_parser_model.sv
// ----------------------------------------
// Frame parser stand-in
// ----------------------------------------
module acm_parser_model (
	// Clock
	input  wire logic        hclk,
	// Parsed header
	output logic             frame_valid,
	output logic             frame_is_ipv4,
	output logic       [7:0] frame_protocol,
	output logic       [7:0] frame_ttl,
	output logic             frame_more_frag,
	output logic      [12:0] frame_frag_offset,
	output logic       [3:0] frame_header_len,
	output logic      [31:0] frame_src_addr,
	output logic      [31:0] frame_dst_addr,
	// Layer 4 sub-results
	output logic             icmp_criteria_ok,
	output logic             udp_criteria_ok,
	output logic             tcp_criteria_ok
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet until the first header
	initial begin
		frame_valid = 1'b0;
		{frame_is_ipv4, frame_protocol, frame_ttl, frame_more_frag, frame_frag_offset, frame_header_len,
			frame_src_addr, frame_dst_addr, icmp_criteria_ok, udp_criteria_ok, tcp_criteria_ok} = '0;
	end

	// One header strobe after an optional stall; fields turn to junk afterwards,
	// since they mean nothing without the strobe
	task automatic send(input int gap, input logic [101:0] hdr);
		repeat (gap) @(posedge hclk);
		frame_valid <= 1'b1;
		{frame_is_ipv4, frame_protocol, frame_ttl, frame_more_frag, frame_frag_offset, frame_header_len,
			frame_src_addr, frame_dst_addr, icmp_criteria_ok, udp_criteria_ok, tcp_criteria_ok} <= hdr;
		@(posedge hclk);
		frame_valid <= 1'b0;
		{frame_is_ipv4, frame_protocol, frame_ttl, frame_more_frag, frame_frag_offset, frame_header_len,
			frame_src_addr, frame_dst_addr, icmp_criteria_ok, udp_criteria_ok, tcp_criteria_ok} <= ~hdr;
	endtask
endmodule

// file: test/tb_ipv4_acl_entry_matcher.sv
module tb_ipv4_acl_entry_matcher;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals and bench state
	// ----------------------------------------
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic  [1:0] htrans;
	logic  [2:0] hsize;
	logic        frame_valid, frame_is_ipv4, frame_more_frag, entry_hit_valid, entry_hit;
	logic  [7:0] frame_protocol, frame_ttl;
	logic [12:0] frame_frag_offset;
	logic  [3:0] frame_header_len;
	logic [31:0] frame_src_addr, frame_dst_addr;
	logic        icmp_criteria_ok, udp_criteria_ok, tcp_criteria_ok;
	logic [13:0] c_ctrl;                  // Entry configuration mirror
	logic  [7:0] c_pr;
	logic [31:0] c_sa, c_sm, c_da, c_dm;
	logic        f_v4, f_mf, last_hit;    // Frame under test
	logic  [7:0] f_pr, f_ttl;
	logic [12:0] f_off;
	logic  [3:0] f_ihl;
	logic [31:0] f_sa, f_da, exp_hits;
	logic  [2:0] f_ok;                    // ICMP, UDP, TCP sub-results
	int          err_count, checks_done, cyc, n_case;
	logic  [7:0] prl [5]  = '{8'h00, 8'h01, 8'h06, 8'h11, 8'hff};
	logic [31:0] flip [5] = '{32'h0, 32'h1, 32'h100, 32'h8000_0000, 32'hffff_ffff};
	logic  [7:0] ttl_t [5] = '{8'h00, 8'h01, 8'hff, 8'h00, 8'h40};
	logic [12:0] off_t [5] = '{13'h0, 13'h0, 13'h1, 13'h1fff, 13'h1000};
	logic  [3:0] ihl_t [5] = '{4'h5, 4'h6, 4'h5, 4'hf, 4'h6};

	assign hready = hreadyout;            // Only one slave on the bus

	acm_entry_matcher DUT (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
		.hresp, .hrdata, .frame_valid, .frame_is_ipv4, .frame_protocol, .frame_ttl, .frame_more_frag,
		.frame_frag_offset, .frame_header_len, .frame_src_addr, .frame_dst_addr, .icmp_criteria_ok,
		.udp_criteria_ok, .tcp_criteria_ok, .entry_hit_valid, .entry_hit
	);
	acm_parser_model PARSER (
		.hclk, .frame_valid, .frame_is_ipv4, .frame_protocol, .frame_ttl, .frame_more_frag,
		.frame_frag_offset, .frame_header_len, .frame_src_addr, .frame_dst_addr, .icmp_criteria_ok,
		.udp_criteria_ok, .tcp_criteria_ok
	);

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	always #5 hclk = ~hclk;
	// About 300 cases of under 20 cycles each; ceiling leaves wide margin
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic logic tri_ok(logic [1:0] m, logic cond);
		return (m == 2'h0) || (m == 2'h1 && !cond) || (m == 2'h2 && cond);
	endfunction
	function automatic logic adr_ok(logic [1:0] m, logic [31:0] fa, logic [31:0] ca, logic [31:0] cm);
		return (m == 2'h0) || (m == 2'h1 && fa == ca) || (m == 2'h2 && ((fa ^ ca) & cm) == 32'h0);
	endfunction
	function automatic logic exp_hit();
		logic p;
		// Layer 4 selections also need their sub-result
		case (c_ctrl[3:1])
			3'h0: p = 1'b1;
			3'h1: p = (f_pr == c_pr);
			3'h2: p = (f_pr == 8'h01) && f_ok[2];
			3'h3: p = (f_pr == 8'h11) && f_ok[1];
			3'h4: p = (f_pr == 8'h06) && f_ok[0];
			default: p = 1'b0;
		endcase
		return c_ctrl[0] && f_v4 && p && tri_ok(c_ctrl[5:4], f_ttl != 8'h0)
			&& tri_ok(c_ctrl[7:6], f_mf || f_off != 13'h0) && tri_ok(c_ctrl[9:8], f_ihl > 4'h5)
			&& adr_ok(c_ctrl[11:10], f_sa, c_sa, c_sm) && adr_ok(c_ctrl[13:12], f_da, c_da, c_dm);
	endfunction

	// ----------------------------------------
	// Compare, bus and case tasks
	// ----------------------------------------
	task automatic cmp_b(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic cmp_w(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Single word transfer; entered just after a rising edge
	task automatic ahb_xfer(input logic [7:0] o, input logic w, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, o};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		cmp_w("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wr(input logic [7:0] o, input logic [31:0] d);
		logic [31:0] r;
		ahb_xfer(o, 1'b1, d, r);
	endtask
	task automatic rd(input logic [7:0] o, input logic [31:0] e);
		logic [31:0] r;
		ahb_xfer(o, 1'b0, 32'h0, r);
		cmp_w($sformatf("register %h", o), e, r);
	endtask
	// Neutral entry and a frame that it accepts
	task automatic set_base();
		c_ctrl = 14'h0001;
		c_pr   = 8'h00;
		c_sa   = 32'hc0a8_0100;
		c_sm   = 32'hffff_ff00;
		c_da   = 32'h0a00_0001;
		c_dm   = 32'hff00_0000;
		{f_v4, f_pr, f_ttl, f_mf, f_off, f_ihl} = {1'b1, 8'h06, 8'h40, 1'b0, 13'h0, 4'h5};
		{f_sa, f_da, f_ok} = {c_sa, c_da, 3'b111};
	endtask
	// Program the entry, present one header, check result and its hold
	task automatic run_case();
		logic e;
		wr(acm_pkg::OFS_CTRL, {18'h0, c_ctrl});
		wr(acm_pkg::OFS_PROTO, {24'h0, c_pr});
		wr(acm_pkg::OFS_SRC, c_sa);
		wr(acm_pkg::OFS_SMASK, c_sm);
		wr(acm_pkg::OFS_DST, c_da);
		wr(acm_pkg::OFS_DMASK, c_dm);
		n_case++;
		PARSER.send(n_case % 3, {f_v4, f_pr, f_ttl, f_mf, f_off, f_ihl, f_sa, f_da, f_ok});
		@(posedge hclk);
		e = exp_hit();
		cmp_b("entry_hit_valid", 1'b1, entry_hit_valid);
		cmp_b("entry_hit", e, entry_hit);
		exp_hits += {31'h0, e};
		last_hit = e;
		@(posedge hclk);
		cmp_b("entry_hit_valid", 1'b0, entry_hit_valid);
		cmp_b("entry_hit", e, entry_hit);
	endtask
	task automatic report_and_stop();
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{hclk, hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'b010;
		{err_count, checks_done, cyc, n_case, exp_hits, last_hit} = '0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		cmp_b("entry_hit", 1'b0, entry_hit);
		// Reset values, unmapped word included
		for (int o = 0; o <= 32; o += 4) begin
			rd(o[7:0], 32'h0);
		end
		wr(acm_pkg::OFS_CTRL, 32'hffff_ffff);
		rd(acm_pkg::OFS_CTRL, 32'h0000_3fff);
		wr(acm_pkg::OFS_PROTO, 32'hffff_ffff);
		rd(acm_pkg::OFS_PROTO, 32'h0000_00ff);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
		// Protocol modes against protocol values and sub-results
		for (int m = 0; m < 8; m++) begin
			for (int p = 0; p < 5; p++) begin
				for (int k = 0; k < 4; k++) begin
					set_base();
					c_ctrl[3:1] = m[2:0];
					c_pr = prl[4 - k];
					f_pr = prl[p];
					f_ok = 3'b111 >> k;
					run_case();
				end
			end
		end
		// TTL, fragment and option modes against header variants
		for (int fld = 0; fld < 3; fld++) begin
			for (int m = 0; m < 4; m++) begin
				for (int v = 0; v < 5; v++) begin
					set_base();
					c_ctrl[4 + 2 * fld +: 2] = m[1:0];
					{f_ttl, f_off, f_ihl, f_mf, f_v4} = {ttl_t[v], off_t[v], ihl_t[v], v == 1, v != 4};
					run_case();
				end
			end
		end
		// Address modes with bits flipped inside and outside the masks
		for (int d = 0; d < 2; d++) begin
			for (int m = 0; m < 4; m++) begin
				for (int v = 0; v < 5; v++) begin
					set_base();
					c_ctrl[10 + 2 * d +: 2] = m[1:0];
					f_sa = (d == 0) ? c_sa ^ flip[v] : f_sa;
					f_da = (d == 1) ? c_da ^ flip[v] : f_da;
					run_case();
				end
			end
		end
		rd(acm_pkg::OFS_SRC, c_sa);
		// Every criterion armed, then each one broken alone
		for (int k = 0; k < 10; k++) begin
			set_base();
			c_ctrl = {2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 3'h4, 1'b1};
			case (k)
				1: c_ctrl[0] = 1'b0;
				2: f_v4 = 1'b0;
				3: f_pr = 8'h11;
				4: f_ttl = 8'h00;
				5: f_mf = 1'b1;
				6: f_ihl = 4'h6;
				7: f_sa[8] = ~f_sa[8];
				8: f_da[0] = ~f_da[0];
				9: f_ok[0] = 1'b0;
				default: f_sa[0] = ~f_sa[0];
			endcase
			run_case();
		end
		// Hit counter and status
		rd(acm_pkg::OFS_HCNT, exp_hits);
		rd(acm_pkg::OFS_STAT, {30'h0, 1'b1, last_hit});
		wr(acm_pkg::OFS_HCNT, 32'h0);
		rd(acm_pkg::OFS_HCNT, 32'h0);
		wr(acm_pkg::OFS_STAT, 32'h2);
		rd(acm_pkg::OFS_STAT, {31'h0, last_hit});
		report_and_stop();
	end
endmodule
